/* rtl/pulse_proc.sv */
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps

module pulse_proc #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        RESETN,
   // Avalon-MM slave
   input  wire logic [7:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   // Real pins 1 to 32, bit 0 is pin 1
   input  wire logic [31:0] PIN_IN,
   output logic      [31:0] PIN_OUT,
   output logic      [31:0] PIN_OE
);

   // Software registers
   logic [7:0]             mode_ff;
   logic [31:0]            src_ff;
   logic [31:0]            lines_ff;
   logic [3:0]             dir_ff;
   logic [CNT_W-1:0]       work_ff;
   logic [CNT_W-1:0]       aux_ff;
   logic                   out_ff;
   pulse_proc_pkg::proc_state_t state_ff;
   // Pin state and edge history
   logic [31:0]            sync1_ff;
   logic [31:0]            sync2_ff;
   logic [63:0]            drive_ff;
   logic                   cnt_prev_ff;
   logic                   trg_prev_ff;
   logic                   gate_prev_ff;
   // Bus handshake
   logic                   req;
   logic                   take;
   logic                   define;

   // Selection fields
   logic [6:0] cnt_sel;
   logic [6:0] trg_sel;
   logic [6:0] gate_sel;
   logic [6:0] out_sel;
   logic [1:0] cnt_edge;
   logic [1:0] trg_edge;
   assign cnt_sel  = src_ff[pulse_proc_pkg::POS_CNT_SRC +: 7];
   assign cnt_edge = src_ff[pulse_proc_pkg::POS_CNT_EDGE +: 2];
   assign trg_sel  = src_ff[pulse_proc_pkg::POS_TRG_LINE +: 7];
   assign trg_edge = src_ff[pulse_proc_pkg::POS_TRG_EDGE +: 2];
   assign gate_sel = lines_ff[pulse_proc_pkg::POS_GATE +: 7];
   assign out_sel  = lines_ff[pulse_proc_pkg::POS_OUT +: 7];

   // Level of a pin code; code zero reads low
   function automatic logic pick(input logic [63:0] vec,
                                 input logic [6:0]  code);
      logic [6:0] idx;
      idx = code - 7'h01;
      if (code == pulse_proc_pkg::PIN_NONE) begin
         pick = 1'b0;
      end else begin
         pick = vec[idx[5:0]];
      end
   endfunction : pick

   // Edge detect by selected edge code
   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic       cur,
                                     input logic       prv);
      case (sel)
         pulse_proc_pkg::EDGE_RISE: edge_hit = cur & ~prv;
         pulse_proc_pkg::EDGE_FALL: edge_hit = ~cur & prv;
         pulse_proc_pkg::EDGE_BOTH: edge_hit = cur ^ prv;
         default:                   edge_hit = 1'b0;
      endcase
   endfunction : edge_hit

   // Byte-lane merge for writes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      merge = (old & ~m) | (wd & m);
   endfunction : merge

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         sync1_ff <= pulse_proc_pkg::RST_REG;
         sync2_ff <= pulse_proc_pkg::RST_REG;
      end else begin
         sync1_ff <= PIN_IN;
         sync2_ff <= sync1_ff;
      end
   end

   // Pin levels: driven pins read back their own drive
   logic [63:0] level;
   assign level = {drive_ff[63:32],
                   (PIN_OE & drive_ff[31:0]) | (~PIN_OE & sync2_ff)};

   logic cnt_lvl;
   logic trg_lvl;
   logic gate_lvl;
   logic data_lvl;
   assign cnt_lvl  = pick(level, cnt_sel);
   assign trg_lvl  = pick(level, trg_sel);
   assign gate_lvl = pick(level, gate_sel);
   assign data_lvl = pick(level, out_sel);

   // Edge history for selected lines
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         cnt_prev_ff  <= 1'b0;
         trg_prev_ff  <= 1'b0;
         gate_prev_ff <= 1'b0;
      end else begin
         cnt_prev_ff  <= cnt_lvl;
         trg_prev_ff  <= trg_lvl;
         gate_prev_ff <= gate_lvl;
      end
   end

   logic cnt_ev;
   logic trg_ev;
   logic gate_fall;
   assign cnt_ev = (cnt_sel == pulse_proc_pkg::PIN_NONE) ? 1'b1 :
                   edge_hit(cnt_edge, cnt_lvl, cnt_prev_ff);
   assign trg_ev = (trg_sel != pulse_proc_pkg::PIN_NONE) &&
                   edge_hit(trg_edge, trg_lvl, trg_prev_ff);
   assign gate_fall = (gate_sel != pulse_proc_pkg::PIN_NONE) &&
                      !gate_lvl && gate_prev_ff;

   // Mode decode
   logic is_osc;
   logic is_gtc;
   logic is_cto;
   logic is_sit;
   logic down;
   assign is_osc = (mode_ff == pulse_proc_pkg::MODE_OSC_UP) ||
                   (mode_ff == pulse_proc_pkg::MODE_OSC_DN);
   assign is_gtc = (mode_ff == pulse_proc_pkg::MODE_GTC_UP) ||
                   (mode_ff == pulse_proc_pkg::MODE_GTC_DN);
   assign is_cto = (mode_ff == pulse_proc_pkg::MODE_CTO_UP) ||
                   (mode_ff == pulse_proc_pkg::MODE_CTO_DN);
   assign is_sit = (mode_ff == pulse_proc_pkg::MODE_SHIFT);
   assign down   = (mode_ff == pulse_proc_pkg::MODE_OSC_DN) ||
                   (mode_ff == pulse_proc_pkg::MODE_GTC_DN) ||
                   (mode_ff == pulse_proc_pkg::MODE_CTO_DN);

   // Stepped count and compare
   logic [CNT_W-1:0] step;
   logic             hit;
   assign step = down ? work_ff - 1'b1 : work_ff + 1'b1;
   assign hit  = (step == aux_ff);

   // trigger accepted only while gate high
   logic cto_acc;
   assign cto_acc = is_cto && trg_ev && gate_lvl;

   // Process state, count and output level
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         state_ff <= pulse_proc_pkg::ST_IDLE;
         work_ff  <= pulse_proc_pkg::RST_COUNT;
         aux_ff   <= pulse_proc_pkg::RST_COUNT;
         out_ff   <= 1'b0;
      end else if (define) begin
         work_ff  <= AVS_WRITEDATA[CNT_W-1:0];
         aux_ff   <= AVS_WRITEDATA[CNT_W-1:0];
         state_ff <= pulse_proc_pkg::ST_IDLE;
         out_ff   <= 1'b0;
      end else if (is_osc) begin
         case (state_ff)
            pulse_proc_pkg::ST_RUN: begin
               if (cnt_ev && hit) begin
                  work_ff  <= pulse_proc_pkg::RST_COUNT;
                  out_ff   <= ~out_ff;
                  state_ff <= pulse_proc_pkg::ST_DONE;
               end else if (cnt_ev) begin
                  work_ff <= step;
               end
            end
            pulse_proc_pkg::ST_DONE: begin
               if (trg_ev) begin
                  out_ff   <= ~out_ff;
                  state_ff <= pulse_proc_pkg::ST_RUN;
               end
            end
            default: begin
               if (trg_ev) begin
                  state_ff <= pulse_proc_pkg::ST_RUN;
               end
            end
         endcase
      end else if (is_gtc) begin
         if (gate_fall && state_ff == pulse_proc_pkg::ST_RUN) begin
            state_ff <= pulse_proc_pkg::ST_IDLE;
         end else if (gate_fall) begin
            // falling gate opens window, count cleared
            work_ff  <= pulse_proc_pkg::RST_COUNT;
            out_ff   <= 1'b0;
            state_ff <= pulse_proc_pkg::ST_RUN;
         end else if (state_ff == pulse_proc_pkg::ST_RUN && cnt_ev) begin
            work_ff <= step;
         end
         // output asserted once count reaches aux
         if (!gate_fall && work_ff == aux_ff &&
             state_ff == pulse_proc_pkg::ST_RUN) begin
            out_ff <= 1'b1;
         end
      end else if (is_cto) begin
         if (cto_acc) begin
            out_ff   <= ~out_ff;
            state_ff <= pulse_proc_pkg::ST_RUN;
         end else if (state_ff == pulse_proc_pkg::ST_RUN && cnt_ev) begin
            if (hit) begin
               // clear, toggle, hold until next trigger
               work_ff  <= pulse_proc_pkg::RST_COUNT;
               out_ff   <= ~out_ff;
               state_ff <= pulse_proc_pkg::ST_DONE;
            end else begin
               work_ff <= step;
            end
         end
      end else if (is_sit) begin
         // serial data from output-pin level into MSB
         if (cnt_ev) begin
            work_ff <= {data_lvl, work_ff[CNT_W-1:1]};
         end
         if (trg_ev) begin
            aux_ff <= work_ff;
         end
      end
   end

   // drive selected output pin; shift mode reads it instead
   logic [63:0] nxt_drive;
   always_comb begin
      nxt_drive = drive_ff;
      if (!is_sit && mode_ff != pulse_proc_pkg::MODE_NONE &&
          out_sel != pulse_proc_pkg::PIN_NONE) begin
         nxt_drive[6'(out_sel - 7'h01)] = out_ff;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         drive_ff <= {pulse_proc_pkg::RST_REG, pulse_proc_pkg::RST_REG};
      end else begin
         drive_ff <= nxt_drive;
      end
   end

   // upper eight of each bank always drive
   // lower eight directed in groups of four
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         PIN_OE <= {8'hFF, 8'h00, 8'hFF, 8'h00};
      end else begin
         PIN_OE <= {8'hFF, {4{dir_ff[3]}}, {4{dir_ff[2]}},
                    8'hFF, {4{dir_ff[1]}}, {4{dir_ff[0]}}};
      end
   end
   assign PIN_OUT = drive_ff[31:0];

   // One wait state per access, then the request is taken
   assign req    = AVS_READ || AVS_WRITE;
   assign take   = req && !AVS_WAITREQUEST;
   assign define = take && AVS_WRITE &&
                   AVS_ADDRESS == pulse_proc_pkg::OFF_PRELOAD;

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         AVS_WAITREQUEST <= 1'b1;
      end else begin
         AVS_WAITREQUEST <= !(req && AVS_WAITREQUEST);
      end
   end

   // Configuration writes
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         mode_ff  <= pulse_proc_pkg::MODE_NONE;
         src_ff   <= pulse_proc_pkg::RST_REG;
         lines_ff <= pulse_proc_pkg::RST_REG;
         dir_ff   <= pulse_proc_pkg::RST_DIR;
      end else if (take && AVS_WRITE) begin
         if (AVS_ADDRESS == pulse_proc_pkg::OFF_MODE) begin
            mode_ff <= AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : mode_ff;
         end else if (AVS_ADDRESS == pulse_proc_pkg::OFF_SRC) begin
            src_ff <= merge(src_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
         end else if (AVS_ADDRESS == pulse_proc_pkg::OFF_LINES) begin
            lines_ff <= merge(lines_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
         end else if (AVS_ADDRESS == pulse_proc_pkg::OFF_DIR) begin
            dir_ff <= AVS_BYTEENABLE[0] ? AVS_WRITEDATA[3:0] : dir_ff;
         end
      end
   end

   // Read data captured while waitrequest is high
   logic [31:0] nxt_rdata;
   always_comb begin
      nxt_rdata = pulse_proc_pkg::RST_REG;
      if (AVS_ADDRESS == pulse_proc_pkg::OFF_MODE) begin
         nxt_rdata[7:0] = mode_ff;
      end else if (AVS_ADDRESS == pulse_proc_pkg::OFF_SRC) begin
         nxt_rdata = src_ff;
      end else if (AVS_ADDRESS == pulse_proc_pkg::OFF_LINES) begin
         nxt_rdata = lines_ff;
      end else if (AVS_ADDRESS == pulse_proc_pkg::OFF_WORK) begin
         nxt_rdata[CNT_W-1:0] = work_ff;
      end else if (AVS_ADDRESS == pulse_proc_pkg::OFF_AUX) begin
         nxt_rdata[CNT_W-1:0] = aux_ff;
      end else if (AVS_ADDRESS == pulse_proc_pkg::OFF_STATUS) begin
         nxt_rdata[3:0] = {state_ff, out_ff};
      end else if (AVS_ADDRESS == pulse_proc_pkg::OFF_DIR) begin
         nxt_rdata[3:0] = dir_ff;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         AVS_READDATA <= pulse_proc_pkg::RST_REG;
      end else if (AVS_READ && AVS_WAITREQUEST) begin
         AVS_READDATA <= nxt_rdata;
      end
   end

   // Checks
   sequence s_osc_match;
      is_osc && state_ff == pulse_proc_pkg::ST_RUN && cnt_ev && hit;
   endsequence

   sequence s_stopped;
      work_ff == pulse_proc_pkg::RST_COUNT &&
      state_ff == pulse_proc_pkg::ST_DONE;
   endsequence

   a_osc_count_up: assert property (
      @(posedge CLK_SYS) disable iff (!RESETN)
      (mode_ff == pulse_proc_pkg::MODE_OSC_UP && !define && !hit &&
       state_ff == pulse_proc_pkg::ST_RUN && cnt_ev)
      |=> work_ff == $past(work_ff) + 16'h0001)
      else $error("one-shot did not step up");

   a_osc_match_stop: assert property (
      @(posedge CLK_SYS) disable iff (!RESETN)
      (s_osc_match and !define) |=> s_stopped ##0 out_ff != $past(out_ff))
      else $error("one-shot compare did not stop");

   a_osc_retrigger: assert property (
      @(posedge CLK_SYS) disable iff (!RESETN)
      (is_osc && !define && state_ff == pulse_proc_pkg::ST_DONE && trg_ev)
      |=> state_ff == pulse_proc_pkg::ST_RUN && out_ff != $past(out_ff))
      else $error("retrigger did not restart");

   a_gate_open: assert property (
      @(posedge CLK_SYS) disable iff (!RESETN)
      (is_gtc && !define && gate_fall &&
       state_ff != pulse_proc_pkg::ST_RUN)
      |=> work_ff == pulse_proc_pkg::RST_COUNT &&
          state_ff == pulse_proc_pkg::ST_RUN)
      else $error("gate window did not open cleared");

   a_gate_close: assert property (
      @(posedge CLK_SYS) disable iff (!RESETN)
      (is_gtc && !define && gate_fall &&
       state_ff == pulse_proc_pkg::ST_RUN)
      |=> state_ff == pulse_proc_pkg::ST_IDLE ##1 $stable(work_ff))
      else $error("gate edge did not stop count");

   a_gate_out_set: assert property (
      @(posedge CLK_SYS) disable iff (!RESETN)
      (is_gtc && !define && !gate_fall && work_ff == aux_ff &&
       state_ff == pulse_proc_pkg::ST_RUN) |=> out_ff)
      else $error("gated compare did not set output");

   a_cto_refuse: assert property (
      @(posedge CLK_SYS) disable iff (!RESETN)
      (is_cto && !define && trg_ev && !gate_lvl &&
       state_ff == pulse_proc_pkg::ST_IDLE)
      |=> $stable(out_ff) && state_ff == pulse_proc_pkg::ST_IDLE)
      else $error("trigger accepted with gate low");

   a_cto_toggle: assert property (
      @(posedge CLK_SYS) disable iff (!RESETN)
      (cto_acc && !define) |=> out_ff != $past(out_ff))
      else $error("accepted trigger did not toggle");

   a_cto_hold: assert property (
      @(posedge CLK_SYS) disable iff (!RESETN)
      (is_cto && !define && !cto_acc && cnt_ev && hit &&
       state_ff == pulse_proc_pkg::ST_RUN)
      |=> s_stopped ##1 (cto_acc || define || !is_cto ||
                         work_ff == pulse_proc_pkg::RST_COUNT))
      else $error("enabled one-shot did not hold");

   a_sit_shift: assert property (
      @(posedge CLK_SYS) disable iff (!RESETN)
      (is_sit && !define && cnt_ev)
      |=> work_ff == {$past(data_lvl), $past(work_ff[CNT_W-1:1])})
      else $error("shift-in step wrong");

   a_sit_sample: assert property (
      @(posedge CLK_SYS) disable iff (!RESETN)
      (is_sit && !define && trg_ev) |=> aux_ff == $past(work_ff))
      else $error("sample not copied to aux");

   a_preload_both: assert property (
      @(posedge CLK_SYS) disable iff (!RESETN)
      define |=> work_ff == $past(AVS_WRITEDATA[CNT_W-1:0]) &&
                 aux_ff == work_ff)
      else $error("preload did not load both");

   a_bus_answer: assert property (
      @(posedge CLK_SYS) disable iff (!RESETN)
      (req && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST)
      else $error("waitrequest not released");

endmodule : pulse_proc

/* rtl/pulse_proc_pkg.sv */
package pulse_proc_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_MODE    = 8'h00;
   localparam logic [7:0] OFF_SRC     = 8'h04;
   localparam logic [7:0] OFF_LINES   = 8'h08;
   localparam logic [7:0] OFF_PRELOAD = 8'h0C;
   localparam logic [7:0] OFF_WORK    = 8'h10;
   localparam logic [7:0] OFF_AUX     = 8'h14;
   localparam logic [7:0] OFF_STATUS  = 8'h18;
   localparam logic [7:0] OFF_DIR     = 8'h1C;

   // Field positions
   localparam int POS_CNT_SRC  = 0;
   localparam int POS_CNT_EDGE = 8;
   localparam int POS_TRG_LINE = 16;
   localparam int POS_TRG_EDGE = 24;
   localparam int POS_GATE     = 0;
   localparam int POS_OUT      = 16;

   // Mode codes
   localparam logic [7:0] MODE_NONE    = 8'h00;
   localparam logic [7:0] MODE_OSC_UP  = 8'h0B;
   localparam logic [7:0] MODE_OSC_DN  = 8'h6F;
   localparam logic [7:0] MODE_GTC_UP  = 8'h0C;
   localparam logic [7:0] MODE_GTC_DN  = 8'h70;
   localparam logic [7:0] MODE_CTO_UP  = 8'h0D;
   localparam logic [7:0] MODE_CTO_DN  = 8'h71;
   localparam logic [7:0] MODE_SHIFT   = 8'h0E;

   // Edge select codes
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // Pin code zero means internal cycle, no trigger or no gate
   localparam logic [6:0] PIN_NONE = 7'h00;

   // Values after reset
   localparam logic [31:0] RST_REG   = 32'h0000_0000;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [3:0]  RST_DIR   = 4'h0;

   // Process states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN  = 3'b010,
      ST_DONE = 3'b100
   } proc_state_t;

endpackage : pulse_proc_pkg

/* tb/pin_world.sv */
`timescale 1ns/100ps

// External digital lines seen by the real pins of the block
module pin_world (
   // Levels the outside world offers
   input  wire logic [31:0] ext_level,
   // Drive side of the block
   input  wire logic [31:0] pin_out,
   input  wire logic [31:0] pin_oe,
   // Level presented back to the block
   output logic      [31:0] pin_in
);

   // driven pins readback
   // A driven pin shows its own drive, so no outside signal can fight it
   always_comb begin
      pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
   end

endmodule : pin_world

/* tb/tb.sv */
`timescale 1ns/100ps

module tb;
   // Bench signals
   logic        clk;
   logic        rst_n;
   logic [7:0]  adr;
   logic        rd;
   logic        wr;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        wait_req;
   logic [31:0] pin_in;
   logic [31:0] pin_out;
   logic [31:0] pin_oe;
   logic [31:0] ext;
   int          err_total;
   int          checked;
   int          i;
   logic [7:0]  md [4] = '{pulse_proc_pkg::MODE_OSC_UP,
      pulse_proc_pkg::MODE_OSC_DN, pulse_proc_pkg::MODE_CTO_UP,
      pulse_proc_pkg::MODE_CTO_DN};

   // Design and outside lines
   // one controller owns all
   pulse_proc uut (.CLK_SYS(clk), .RESETN(rst_n), .AVS_ADDRESS(adr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
      .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wait_req), .PIN_IN(pin_in), .PIN_OUT(pin_out),
      .PIN_OE(pin_oe));
   pin_world pw (.ext_level(ext), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_in(pin_in));

   // Clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic end_of_test;
      if (err_total == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // Request raised just after an edge, held until waitrequest low
   // The leading edge keeps back-to-back calls from re-driving a strobe
   // in the time step that released it; the watchdog ends a hang
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      adr  <= a;
      wdat <= d;
      wr   <= w;
      rd   <= !w;
      do begin
         @(posedge clk);
      end while (wait_req !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wreg

   task automatic rreg(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask : rreg

   // One high pulse on real pin n, long enough for sync and edge logic
   task automatic pulse(input int n);
      ext[n-1] <= 1'b1;
      cyc(6);
      ext[n-1] <= 1'b0;
      cyc(6);
   endtask : pulse

   function automatic logic [31:0] src(input int c, input int ce,
                                        input int t, input int te);
      return (32'(c) << pulse_proc_pkg::POS_CNT_SRC)
         | (32'(ce) << pulse_proc_pkg::POS_CNT_EDGE)
         | (32'(t) << pulse_proc_pkg::POS_TRG_LINE)
         | (32'(te) << pulse_proc_pkg::POS_TRG_EDGE);
   endfunction : src

   // Preload written last, since it defines the process
   task automatic cfg(input logic [7:0] m, input logic [31:0] s,
                      input logic [31:0] l, input logic [31:0] p);
      wreg(pulse_proc_pkg::OFF_MODE, {24'h0, m});
      wreg(pulse_proc_pkg::OFF_SRC, s);
      wreg(pulse_proc_pkg::OFF_LINES, l);
      wreg(pulse_proc_pkg::OFF_PRELOAD, p);
   endtask : cfg

   // Watchdog, well above the longest compare run
   initial begin
      repeat (90000) @(posedge clk);
      err_total++;
      end_of_test();
   end

   // Main sequence
   initial begin
      rst_n = 1'b0;
      adr = 8'h00;
      rd = 1'b0;
      wr = 1'b0;
      wdat = 32'h0;
      ext = 32'h0;
      err_total = 0;
      checked = 0;
      cyc(4);
      rst_n <= 1'b1;
      chk(pin_oe, 32'hFF00FF00);
      rreg(8'h20, 32'h0);
      wreg(pulse_proc_pkg::OFF_WORK, 32'h0000FFFF);
      rreg(pulse_proc_pkg::OFF_WORK, 32'h0);
      wreg(pulse_proc_pkg::OFF_DIR, 32'h5);
      cyc(2);
      chk(pin_oe, 32'hFF0FFF0F);
      wreg(pulse_proc_pkg::OFF_DIR, 32'h0);
      // Both one-shot kinds, up and down, counting on pin 3
      // output on real pin 9
      for (i = 0; i < 4; i++) begin
         cfg(md[i], src(3, 1, 1, 1), 32'h0009_0000 | (i > 1 ? 4 : 0),
             32'h10);
         rreg(pulse_proc_pkg::OFF_AUX, 32'h10);
         if (i > 1) begin
            pulse(1);
            rreg(pulse_proc_pkg::OFF_STATUS, 32'h2);
            ext[3] <= 1'b1;
            cyc(6);
         end
         pulse(1);
         pulse(3);
         pulse(3);
         rreg(pulse_proc_pkg::OFF_WORK, i % 2 ? 32'hE : 32'h12);
         rreg(pulse_proc_pkg::OFF_STATUS, i > 1 ? 32'h5 : 32'h4);
         ext[3] <= 1'b0;
         cyc(6);
      end
      // Full wrap on the internal cycle reaches the compare value
      // internal cycle as source
      cfg(pulse_proc_pkg::MODE_OSC_UP, src(0, 1, 1, 1), 32'h0009_0000, 0);
      pulse(1);
      cyc(65536);
      rreg(pulse_proc_pkg::OFF_STATUS, 32'h9);
      rreg(pulse_proc_pkg::OFF_WORK, 32'h0);
      chk({31'h0, pin_out[8]}, 32'h1);
      pulse(1);
      rreg(pulse_proc_pkg::OFF_STATUS, 32'h4);
      chk({31'h0, pin_out[8]}, 32'h0);
      // Gated count, trigger line left at zero
      // trigger code zero, unused
      cfg(pulse_proc_pkg::MODE_GTC_UP, src(3, 1, 0, 0), 32'h0009_0004, 3);
      pulse(4);
      rreg(pulse_proc_pkg::OFF_WORK, 32'h0);
      for (i = 0; i < 3; i++)
         pulse(3);
      rreg(pulse_proc_pkg::OFF_STATUS, 32'h5);
      pulse(4);
      pulse(3);
      rreg(pulse_proc_pkg::OFF_WORK, 32'h3);
      cfg(pulse_proc_pkg::MODE_GTC_DN, src(3, 1, 0, 0), 32'h0009_0004, 3);
      pulse(4);
      pulse(3);
      pulse(3);
      rreg(pulse_proc_pkg::OFF_WORK, 32'hFFFE);
      // Enabled one-shot takes over the running count, aux still 3
      // compare, then hold at zero
      wreg(pulse_proc_pkg::OFF_MODE, {24'h0, pulse_proc_pkg::MODE_CTO_UP});
      for (i = 0; i < 5; i++)
         pulse(3);
      rreg(pulse_proc_pkg::OFF_STATUS, 32'h9);
      pulse(3);
      rreg(pulse_proc_pkg::OFF_WORK, 32'h0);
      // Shift-in, output and gate on the same input pin
      // output and gate share pin 2
      cfg(pulse_proc_pkg::MODE_SHIFT, src(3, 1, 1, 1), 32'h0002_0002, 0);
      for (i = 0; i < 3; i++) begin
         ext[1] <= (i != 1);
         cyc(4);
         pulse(3);
      end
      rreg(pulse_proc_pkg::OFF_WORK, 32'hA000);
      pulse(1);
      rreg(pulse_proc_pkg::OFF_AUX, 32'hA000);
      end_of_test();
   end

endmodule : tb
